//--- rtl/icfr_pkg.sv
// package: constants and carrier types for the instruction class and fp result block
`default_nettype none
package icfr_pkg;
  // instruction word and register file geometry
  localparam int unsigned insn_bytes = 4;
  localparam int unsigned insn_width = 8 * insn_bytes;
  localparam int unsigned reg_count = 32;
  localparam int unsigned reg_index_width = 5;
  localparam int unsigned float_reg_width = 64;
  // instruction fields (bit 0 is the lsb, little-endian numbering)
  localparam int unsigned primary_lsb = 26;
  localparam int unsigned primary_width = 6;
  localparam int unsigned ext_lsb = 1;
  localparam int unsigned ext_width = 10;
  localparam int unsigned rd_lsb = 21;
  localparam int unsigned ra_lsb = 16;
  // control register bit that selects non-ieee mode
  localparam int unsigned non_ieee_bit_pos = 29;
  localparam int unsigned status_reg_width = 32;
  // single-precision integer result in non-ieee invalid case
  localparam logic [31:0] int_invalid_pattern = 32'h0000_8000;
  // primary opcodes
  localparam logic [5:0] op_trap_imm = 6'h03;
  localparam logic [5:0] op_syscall = 6'h11;
  localparam logic [5:0] op_cond_reg = 6'h13;
  localparam logic [5:0] op_ext_int = 6'h1f;
  localparam logic [5:0] op_fp_single = 6'h3b;
  localparam logic [5:0] op_fp_double = 6'h3f;
  // extended opcodes of instructions the device does not implement
  localparam logic [9:0] xo_fp_sqrt = 10'h016;
  localparam logic [9:0] xo_xlate_flush = 10'h172;
  // double-word memory ops and the algebraic word load, defined for 64-bit parts only (primary 31)
  localparam logic [9:0] xo_dw_load_idx = 10'h015;
  localparam logic [9:0] xo_dw_store_idx = 10'h095;
  localparam logic [9:0] xo_dw_load_upd = 10'h035;
  localparam logic [9:0] xo_dw_store_upd = 10'h0b5;
  localparam logic [9:0] xo_word_load_alg = 10'h155;

  typedef enum logic [2:0] {
    icfr_defined = 3'b001,
    icfr_reserved = 3'b010,
    icfr_illegal = 3'b100
  } icfr_class_type;

  typedef enum logic [2:0] {
    icfr_res_denorm = 3'b000,
    icfr_res_normal = 3'b001,
    icfr_res_nan = 3'b010,
    icfr_res_int = 3'b011
  } icfr_kind_type;

  typedef struct packed {
    logic valid;
    logic [insn_width-1:0] word;
    logic [31:0] addr;
  } icfr_fetch_type;

  typedef struct packed {
    logic valid;
    logic double;
    icfr_kind_type kind;
    logic invalid_op;
    logic [float_reg_width-1:0] value;
    logic [reg_index_width-1:0] target;
  } icfr_fpres_type;

  typedef struct packed {
    logic valid;
    icfr_class_type cls;
    logic illegal;
    logic misaligned;
    logic mem_access;
    logic [insn_width-1:0] word;
  } icfr_decode_type;

  typedef struct packed {
    logic valid;
    logic unsupported;
    logic [reg_index_width-1:0] target;
    logic [float_reg_width-1:0] value;
  } icfr_fpwrite_type;
endpackage : icfr_pkg
`default_nettype wire

//--- rtl/icfr_unit.sv
// instruction classifier and floating-point result shaper
//
// Function
// - single denormal result is a padded single denormal in ieee mode and zero in non-ieee.
// - double denormal result passes in ieee mode and becomes zero in non-ieee mode.
// - single integer result goes to the low word; non-ieee invalid writes 0x8000 there.
// - double integer-conversion results are not supported and are flagged, never written.
// - every instruction is one aligned four-byte word; a misaligned fetch is still decoded and only flagged in decode.misaligned.
// - there are 32 general and 32 floating-point registers.
// - only load and store instructions touch memory.
// - class comes from primary and extended opcode; anything unknown is illegal, except a nonzero word with primary 0, which is reserved.
// - opcodes defined only for 64-bit parts are illegal here.
// - bad reserved-field bits never raise privilege or change user state.
// - all 32-bit instructions run except square root, single square root and tlb flush-all.
// - unimplemented defined instructions raise the illegal-instruction exception.
// - non-ieee mode is active whenever bit 2 (bit 29 counted from the msb) of the fp status control register is set.
// - the all-zero word is always illegal.
`default_nettype none
module icfr_unit
  import icfr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire icfr_fetch_type fetch,
  input wire logic [status_reg_width-1:0] fp_status_control_reg,
  input wire icfr_fpres_type fp_result,
  output icfr_decode_type decode,
  output logic illegal_insn,
  output icfr_fpwrite_type fp_write
);

  function automatic logic is_mem_primary(input logic [5:0] op);
    is_mem_primary = (op >= 6'h20) && (op <= 6'h37);
  endfunction : is_mem_primary

  // extended opcodes under primary 31 (x form), 32-bit subset
  function automatic logic x_defined(input logic [9:0] xo);
    unique case (xo)
      10'h000, 10'h004, 10'h008, 10'h00a, 10'h00b, 10'h013, 10'h014, 10'h017,
      10'h018, 10'h01a, 10'h01c, 10'h020, 10'h028, 10'h036, 10'h037, 10'h03c,
      10'h04b, 10'h053, 10'h056, 10'h057, 10'h068, 10'h077, 10'h07c, 10'h088,
      10'h08a, 10'h090, 10'h092, 10'h096, 10'h097, 10'h0b7, 10'h0c8, 10'h0ca,
      10'h0d2, 10'h0d7, 10'h0e9, 10'h0ea, 10'h0eb, 10'h0f2, 10'h0f6, 10'h0f7,
      10'h10a, 10'h112, 10'h116, 10'h117, 10'h11c, 10'h136, 10'h137, 10'h13c,
      10'h153, 10'h157, 10'h173, 10'h177, 10'h197, 10'h19c, 10'h1b7, 10'h1bc,
      10'h1c6, 10'h1cb, 10'h1cc, 10'h1d3, 10'h1d6, 10'h1dc, 10'h1eb, 10'h200,
      10'h208, 10'h20a, 10'h215, 10'h216, 10'h217, 10'h218, 10'h236, 10'h237,
      10'h253, 10'h255, 10'h256, 10'h257, 10'h277, 10'h293, 10'h295, 10'h296,
      10'h297, 10'h2b7, 10'h2d5, 10'h2d7, 10'h2f2, 10'h2f7, 10'h316, 10'h318,
      10'h31a, 10'h336, 10'h338, 10'h356, 10'h396, 10'h39a, 10'h3ba, 10'h3d2,
      10'h3d6, 10'h3d7, 10'h3f6, 10'h28a, 10'h0e8, 10'h0c0,
      10'h2eb, 10'h3cb, 10'h3eb, 10'h1e8, 10'h3e8, 10'h2e8, 10'h1e0:
        x_defined = 1'b1;
      default:
        x_defined = 1'b0;
    endcase
  endfunction : x_defined

  function automatic logic cr_defined(input logic [9:0] xo);
    unique case (xo)
      10'h000, 10'h010, 10'h021, 10'h032, 10'h081, 10'h096, 10'h0c1, 10'h0e1,
      10'h101, 10'h121, 10'h1a1, 10'h1c1, 10'h210:
        cr_defined = 1'b1;
      default:
        cr_defined = 1'b0;
    endcase
  endfunction : cr_defined

  // double fp: xo bits 1..5 for a-form, else the full field
  function automatic logic fpd_defined(input logic [9:0] xo);
    logic [4:0] a_xo;
    a_xo = xo[4:0];
    if (a_xo >= 5'h12 && a_xo != 5'h13 && a_xo != 5'h16 && a_xo != 5'h1b)
      fpd_defined = 1'b1;
    else
    begin
      unique case (xo)
        10'h000, 10'h00c, 10'h00e, 10'h00f, 10'h020, 10'h026, 10'h028, 10'h040,
        10'h046, 10'h048, 10'h046 ^ 10'h0c0, 10'h088, 10'h108, 10'h247, 10'h2c7:
          fpd_defined = 1'b1;
        default:
          fpd_defined = 1'b0;
      endcase
    end
  endfunction : fpd_defined

  function automatic logic fps_defined(input logic [4:0] a_xo);
    unique case (a_xo)
      5'h12, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1c, 5'h1d, 5'h1e, 5'h1f:
        fps_defined = 1'b1;
      default:
        fps_defined = 1'b0;
    endcase
  endfunction : fps_defined

  wire logic [5:0] primary = fetch.word[primary_lsb +: primary_width];
  wire logic [9:0] ext = fetch.word[ext_lsb +: ext_width];
  wire logic word_zero = (fetch.word == '0);
  // the block can see a fetch address that is not word aligned and flags it
  // word alignment check
  wire logic misaligned = (fetch.addr[1:0] != 2'b00);
  wire logic op64 = (primary == 6'h02) || (primary == 6'h1e) || (primary == 6'h3a)
    || (primary == 6'h3e)
    || ((primary == op_ext_int) && ((ext == xo_dw_load_idx) || (ext == xo_dw_store_idx)
    || (ext == xo_dw_load_upd) || (ext == xo_dw_store_upd) || (ext == xo_word_load_alg)));
  wire logic unimpl = ((primary == op_fp_double) && (ext[4:0] == xo_fp_sqrt[4:0]))
    || ((primary == op_fp_single) && (ext[4:0] == xo_fp_sqrt[4:0]))
    || ((primary == op_ext_int) && (ext == xo_xlate_flush));
  wire logic no_ext = (primary == op_trap_imm) || (primary == 6'h07) || (primary == 6'h08)
    || ((primary >= 6'h0a) && (primary <= 6'h0e)) || (primary == 6'h0f)
    || (primary == 6'h10) || (primary == op_syscall) || (primary == 6'h12)
    || ((primary >= 6'h14) && (primary <= 6'h15)) || (primary == 6'h17)
    || ((primary >= 6'h18) && (primary <= 6'h1d)) || is_mem_primary(primary);
  // class from primary and extended opcode
  wire logic known = no_ext || ((primary == op_cond_reg) && cr_defined(ext))
    || ((primary == op_ext_int) && x_defined(ext))
    || ((primary == op_fp_double) && fpd_defined(ext))
    || ((primary == op_fp_single) && fps_defined(ext[4:0]));
  // only a zero primary with nonzero remainder counts as reserved
  wire logic reserved = (primary == 6'h00) && !word_zero;
  wire logic defined_ok = known && !op64 && !unimpl && !word_zero;
  wire icfr_class_type next_cls = defined_ok ? icfr_defined
    : (reserved ? icfr_reserved : icfr_illegal);
  // raise for illegal, unimplemented and unimplemented reserved
  wire logic next_illegal = fetch.valid && (next_cls != icfr_defined);
  // only load or store primaries reach memory
  wire logic next_mem = fetch.valid && defined_ok && is_mem_primary(primary);
  // no state or privilege is changed here; a bad word only ever traps

  wire logic non_ieee_mode_bit = fp_status_control_reg[status_reg_width-1-non_ieee_bit_pos];
  wire logic [float_reg_width-1:0] single_denorm = {fp_result.value[63:29], 29'h0};
  logic [float_reg_width-1:0] next_value;
  wire logic next_unsup = fp_result.valid && fp_result.double
    && (fp_result.kind == icfr_res_int);

  always_comb
  begin
    next_value = fp_result.value;
    unique case (fp_result.kind)
      icfr_res_denorm:
        if (non_ieee_mode_bit)
          next_value = '0;
        else if (!fp_result.double)
          next_value = single_denorm;
      icfr_res_int:
        next_value = {32'h0, (non_ieee_mode_bit && fp_result.invalid_op)
          ? int_invalid_pattern : fp_result.value[31:0]};
      default:
        next_value = fp_result.value;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      decode <= '0;
      illegal_insn <= 1'b0;
      fp_write <= '0;
    end
    else
    begin
      decode <= '{valid: fetch.valid, cls: next_cls, illegal: next_illegal,
        misaligned: fetch.valid && misaligned, mem_access: next_mem, word: fetch.word};
      illegal_insn <= next_illegal;
      fp_write <= '{valid: fp_result.valid && !next_unsup, unsupported: next_unsup,
        target: fp_result.target, value: next_value};
    end
  end

  illegal_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fetch.valid && (fetch.word == '0) |=> illegal_insn && decode.illegal)
    else $error("zero word not flagged");
  zero_word_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (fetch.word == '0) |=> decode.cls == icfr_illegal)
    else $error("zero word not illegal");
  op64_illegal_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fetch.valid && (primary == 6'h1e) |=> illegal_insn)
    else $error("64-bit opcode accepted");
  tlb_flush_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fetch.valid && (primary == op_ext_int) && (ext == xo_xlate_flush) |=> illegal_insn)
    else $error("flush-all not trapped");
  mem_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
    decode.mem_access |-> is_mem_primary(decode.word[primary_lsb +: primary_width]))
    else $error("non load store marked memory");
  denorm_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fp_result.valid && fp_result.kind == icfr_res_denorm && non_ieee_mode_bit
    |=> fp_write.value == '0)
    else $error("denormal not zeroed");
  single_pad_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fp_result.valid && fp_result.kind == icfr_res_denorm && !fp_result.double
    && !non_ieee_mode_bit |=> fp_write.value[28:0] == '0)
    else $error("single denormal not padded");
  int_invalid_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fp_result.valid && fp_result.kind == icfr_res_int && non_ieee_mode_bit
    && fp_result.invalid_op |=> fp_write.value[31:0] == int_invalid_pattern)
    else $error("invalid integer pattern wrong");
  double_int_a: assert property (@(posedge mclk) disable iff (!reset_n)
    fp_result.valid && fp_result.double && fp_result.kind == icfr_res_int
    |=> !fp_write.valid && fp_write.unsupported)
    else $error("double integer written");
endmodule : icfr_unit
`default_nettype wire

//--- verif/icfr_testbench.sv
// self-checking bench for the instruction classifier and fp result shaper
`default_nettype none
module testbench
  import icfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 1'b0;
  logic reset_n;
  icfr_fetch_type fetch;
  logic [status_reg_width-1:0] fp_status_control_reg;
  icfr_fpres_type fp_result;
  icfr_decode_type decode;
  logic illegal_insn;
  icfr_fpwrite_type fp_write;
  int mismatches = 0;
  int checked = 0;
  logic [31:0] lfsr;
  logic [5:0] ill_ops [14] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16, 6'h38, 6'h39,
    6'h3c, 6'h3d, 6'h02, 6'h1e, 6'h3a, 6'h3e};
  logic [15:0] xo_list [8] = '{{op_ext_int, xo_dw_load_idx}, {op_ext_int, xo_dw_store_idx},
    {op_ext_int, xo_dw_load_upd}, {op_ext_int, xo_dw_store_upd}, {op_ext_int, xo_word_load_alg},
    {op_fp_double, xo_fp_sqrt}, {op_fp_single, xo_fp_sqrt}, {op_ext_int, xo_xlate_flush}};
  icfr_kind_type kinds [4] = '{icfr_res_denorm, icfr_res_normal, icfr_res_nan, icfr_res_int};

  icfr_unit DUT (
    .mclk(mclk),
    .reset_n(reset_n),
    .fetch(fetch),
    .fp_status_control_reg(fp_status_control_reg),
    .fp_result(fp_result),
    .decode(decode),
    .illegal_insn(illegal_insn),
    .fp_write(fp_write)
  );

  always #10 mclk = ~mclk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic fetch_word(input logic [31:0] w, input logic [31:0] a, input logic ill,
    input logic [2:0] cls);
    fetch = '{valid: 1'b1, word: w, addr: a};
    @(negedge mclk);
    check("decode.valid", decode.valid, 1'b1);
    check("decode.cls", decode.cls, cls);
    check("illegal_insn", illegal_insn, ill);
    check("decode.illegal", decode.illegal, ill);
    check("decode.word", decode.word, w);
    check("decode.misaligned", decode.misaligned, a[1:0] != 2'b00);
  endtask : fetch_word

  task automatic idle();
    fetch.valid = 1'b0;
    fp_result.valid = 1'b0;
    @(negedge mclk);
    check("decode.valid idle", decode.valid, 1'b0);
    check("illegal_insn idle", illegal_insn, 1'b0);
    check("fp_write.valid idle", fp_write.valid, 1'b0);
  endtask : idle

  task automatic fp_step(input logic ni, input logic dbl, input icfr_kind_type k,
    input logic inv);
    logic [63:0] v;
    logic [63:0] e;
    logic [4:0] tgt;
    logic uns;
    lfsr = lfsr_next(lfsr);
    v = {lfsr, lfsr_next(lfsr)};
    tgt = lfsr[4:0];
    // unrelated status bits are random so only the mode bit may matter
    fp_status_control_reg = {lfsr[31:3], ni, lfsr[1:0]};
    fp_result = '{valid: 1'b1, double: dbl, kind: k, invalid_op: inv, value: v, target: tgt};
    uns = dbl && k == icfr_res_int;
    e = v;
    if (k == icfr_res_denorm)
      e = ni ? 64'h0 : (dbl ? v : {v[63:29], 29'h0});
    if (k == icfr_res_int && !dbl)
      e = {32'h0, (ni && inv) ? int_invalid_pattern : v[31:0]};
    @(negedge mclk);
    check("fp_write.valid", fp_write.valid, !uns);
    check("fp_write.unsupported", fp_write.unsupported, uns);
    check("fp_write.target", fp_write.target, tgt);
    if (!uns)
      check("fp_write.value", fp_write.value, e);
  endtask : fp_step

  initial
  begin
    reset_n = 1'b0;
    fetch = '0;
    fp_result = '0;
    fp_status_control_reg = '0;
    lfsr = 32'h39ade1c1;
    repeat (5) @(negedge mclk);
    check("decode.valid reset", decode.valid, 1'b0);
    check("illegal_insn reset", illegal_insn, 1'b0);
    reset_n = 1'b1;
    @(negedge mclk);
    fetch_word(32'h0, 32'h0, 1'b1, icfr_illegal);
    check("decode.mem_access", decode.mem_access, 1'b0);
    fetch_word(32'h4400_0002, 32'h0000_0006, 1'b0, icfr_defined);
    check("decode.mem_access sc", decode.mem_access, 1'b0);
    fetch_word(32'h8000_0000, 32'h0000_0004, 1'b0, icfr_defined);
    check("decode.mem_access load", decode.mem_access, 1'b1);
    idle();
    foreach (ill_ops[i])
    begin
      lfsr = lfsr_next(lfsr);
      fetch_word({ill_ops[i], lfsr[25:0]}, lfsr, 1'b1, icfr_illegal);
    end
    foreach (xo_list[i])
    begin
      fetch_word({xo_list[i][15:10], 15'h0, xo_list[i][9:0], 1'b0}, 32'h0000_0100, 1'b1,
        icfr_illegal);
    end
    fetch_word(32'h0000_0001, 32'h0000_0200, 1'b1, icfr_reserved);
    idle();
    for (int m = 0; m < 32; m++)
      fp_step(m[0], m[1], kinds[m / 8], m[2]);
    idle();
    stop_test();
  end

  initial
  begin
    #40000;
    mismatches++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
